// ==== inc/serial_pkg.sv ====
// constants shared by the serial status and clock select logic
package serial_pkg;
  // ===========================================================
  // register map
  localparam logic [3:0] STATUS_ADDR  = 4'h0;
  localparam logic [3:0] CONTROL_ADDR = 4'h1;
  localparam logic [3:0] TX_DATA_ADDR = 4'h2;
  localparam logic [3:0] RX_DATA_ADDR = 4'h3;
  // ===========================================================
  // status fields
  localparam int TX_EMPTY_BIT  = 7;
  localparam int RX_FULL_BIT   = 6;
  localparam int OVERRUN_BIT   = 5;
  localparam int FRAMING_BIT   = 4;
  localparam int PARITY_BIT    = 3;
  localparam int TX_DONE_BIT   = 2;
  localparam int MP_RX_BIT     = 1;
  localparam int MP_TX_BIT     = 0;
  localparam logic [7:0] STATUS_RESET = 8'h84;
  // ===========================================================
  // control fields
  localparam int CLK_OUT_EN_BIT = 0;
  localparam int CLK_SRC_BIT    = 1;
  localparam int RX_ON_BIT      = 4;
  localparam int TX_ON_BIT      = 5;
  localparam int SYNC_MODE_BIT  = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_MASK  = 8'hB3;
  // ===========================================================
  // timing
  localparam logic [4:0] EXT_OVERSAMPLE = 5'h10;
  localparam logic [7:0] BIT_HALF_CYCLES = 8'h08;
endpackage

// ==== sim/remote_serial_dev.sv ====
// remote serial device: clock pin source and finished characters
`timescale 1ns/1ps
module remote_serial_dev (
  input  wire logic       mclk,
  output logic            far_sclk,
  output logic            rx_char_done,
  output logic      [7:0] rx_char_data,
  output logic            rx_char_frame_err,
  output logic            rx_char_parity_err,
  output logic            rx_char_mp_bit
);
  initial begin
    far_sclk = 1'b0;
    {rx_char_done, rx_char_frame_err, rx_char_parity_err} = 3'h0;
    rx_char_mp_bit = 1'b0;
    rx_char_data = 8'hA5;
  end
  // burst of link clocks, 160 ns period, low between bursts
  task automatic send_clocks(input int n);
    #7;
    repeat (n) begin
      #80 far_sclk = 1'b1;
      #80 far_sclk = 1'b0;
    end
  endtask
  task automatic send_char(input logic [7:0] d, input logic fe, pe);
    @(posedge mclk);
    rx_char_done       <= 1'b1;
    rx_char_data       <= d;
    rx_char_frame_err  <= fe;
    rx_char_parity_err <= pe;
    rx_char_mp_bit     <= d[7];
    @(posedge mclk);
    rx_char_done       <= 1'b0;
    rx_char_data       <= ~d;
    rx_char_mp_bit     <= ~d[7];
  endtask
endmodule

// ==== sim/serial_status_clk_sel_chk.sv ====
// assertions on the ports of the serial status and clock select block
`timescale 1ns/1ps
module serial_status_clk_sel_chk #(
  parameter logic [7:0] BIT_HALF = serial_pkg::BIT_HALF_CYCLES
) (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       standby,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       dma_tx_write,
  input wire logic [7:0] dma_tx_data,
  input wire logic [7:0] tx_holding_reg,
  input wire logic       tx_go_reg,
  input wire logic       mp_send_reg,
  input wire logic       sclk_out,
  input wire logic       sclk_oe_n,
  input wire logic       ext_bit_tick_reg,
  input wire logic       ext_sync_edge_reg
);
  // ===========================================================
  // helper state
  logic [7:0]  ctl;
  logic        prev;
  logic        armed;
  logic [15:0] gap;
  wire         rise  = sclk_out & ~prev;
  wire         drive = ~ctl[1] & (ctl[7] | ctl[0]);
  wire         st_wr = reg_wr && reg_addr == serial_pkg::STATUS_ADDR;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctl   <= 8'h00;
      prev  <= 1'b1;
      armed <= 1'b0;
      gap   <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == serial_pkg::CONTROL_ADDR) begin
        ctl <= reg_wdata & serial_pkg::CONTROL_MASK;
      end
      prev  <= sclk_out;
      armed <= ~sclk_oe_n & (armed | rise);
      gap   <= rise ? 16'h0001 : gap + 16'h0001;
    end
  end
  // ===========================================================
  // properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  sequence s_mp_wr;
    st_wr ##1 !st_wr && !standby;
  endsequence
  sequence s_stby;
    standby ##1 standby && reg_rd && reg_addr == serial_pkg::STATUS_ADDR;
  endsequence
  property p_pin_dir;
    ctl == $past(ctl) |-> sclk_oe_n == !drive;
  endproperty
  property p_clk_rate;
    rise && armed && !sclk_oe_n |-> gap == {7'h00, BIT_HALF, 1'b0};
  endproperty
  property p_standby;
    s_stby |=> reg_rdata == serial_pkg::STATUS_RESET;
  endproperty
  property p_dma_wr;
    dma_tx_write |=> tx_holding_reg == $past(dma_tx_data);
  endproperty
  property p_mp_send;
    s_mp_wr |=> mp_send_reg == $past(reg_wdata[0], 2);
  endproperty
  property p_tx_off;
    !ctl[5] && !$past(ctl[5]) |-> !tx_go_reg;
  endproperty
  property p_ext_tick;
    ext_bit_tick_reg |-> $past(ctl[1]) && !$past(ctl[7]);
  endproperty
  property p_sync_edge;
    ext_sync_edge_reg |-> $past(ctl[1]) && $past(ctl[7]);
  endproperty
  a_pin_dir: assert property (p_pin_dir)
    else $error("clock pin direction wrong for mode");
  a_clk_rate: assert property (p_clk_rate)
    else $error("clock out period wrong");
  a_standby: assert property (p_standby)
    else $error("status not at reset value in standby");
  a_dma_wr: assert property (p_dma_wr)
    else $error("transfer write not in tx holding");
  a_mp_send: assert property (p_mp_send)
    else $error("mp send bit not written");
  a_tx_off: assert property (p_tx_off)
    else $error("transmit active with tx off");
  a_ext_tick: assert property (p_ext_tick)
    else $error("ext bit tick outside async external mode");
  a_sync_edge: assert property (p_sync_edge)
    else $error("sync edge outside sync external mode");
endmodule
bind serial_status_clk_sel serial_status_clk_sel_chk #(
  .BIT_HALF(BIT_HALF)
) i_chk (.*);

// ==== sim/serial_status_clk_sel_tb.sv ====
// self-checking bench for serial status and clock select
`timescale 1ns/1ps
module serial_status_clk_sel_tb;
  localparam logic [7:0] BIT_HALF = 8'h02;
  localparam logic [3:0] SA = serial_pkg::STATUS_ADDR;
  localparam logic [3:0] CA = serial_pkg::CONTROL_ADDR;
  localparam logic [3:0] RA = serial_pkg::RX_DATA_ADDR;
  logic       mclk, arst_n, standby, reg_wr, reg_rd, sclk_in;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, dma_tx_data, rx_holding_reg;
  logic [7:0] tx_holding_reg, rx_char_data;
  logic       dma_tx_write, dma_rx_read, tx_shift_load, tx_last_bit_done;
  logic       tx_go_reg, mp_send_reg, rx_char_done, rx_char_frame_err;
  logic       rx_char_parity_err, rx_char_mp_bit, rx_go_reg, far_sclk;
  logic       sclk_out, sclk_oe_n, use_ext_clk_reg, ext_bit_tick_reg;
  logic       ext_sync_edge_reg, int_bit_tick;
  int         n_mismatch, tests_run, n_tick, n_edge, cyc, n_int;
  assign sclk_in = sclk_oe_n ? far_sclk : sclk_out;
  serial_status_clk_sel #(.BIT_HALF(BIT_HALF)) i_dut (.*);
  remote_serial_dev i_far (.*);
  // ===========================================================
  // bus and compare tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // status read with bits 2 and 1 masked
  task automatic st(input logic [7:0] exp);
    logic [7:0] d;
    rd(SA, d);
    chk(d & 8'hF9, exp);
  endtask
  // 3 tx write, 2 shift load, 1 last bit, 0 rx read
  task automatic pulse(input int k);
    @(posedge mclk);
    {dma_tx_write, tx_shift_load, tx_last_bit_done, dma_rx_read} <= 4'h1 << k;
    @(posedge mclk);
    {dma_tx_write, tx_shift_load, tx_last_bit_done, dma_rx_read} <= 4'h0;
    #1;
  endtask
  // ===========================================================
  // scenarios
  task automatic t_reset;
    logic [7:0] d;
    st(8'h80);
    wr(SA, 8'hFF);
    rd(SA, d);
    chk(d, 8'h85);
    wr(SA, 8'h00);
    st(8'h80);
    $display("reset test done");
  endtask
  task automatic t_rx;
    logic [7:0] d;
    wr(CA, 8'h30);
    i_far.send_char(8'h5A, 1'b0, 1'b0);
    wr(SA, 8'h00);
    st(8'h40);
    i_far.send_char(8'h33, 1'b0, 1'b0);
    rd(RA, d);
    chk(d, 8'h5A);
    st(8'h60);
    chk({7'h00, rx_go_reg}, 8'h00);
    wr(CA, 8'h20);
    st(8'h60);
    pulse(0);
    st(8'h20);
    wr(SA, 8'h00);
    st(8'h00);
    $display("receive test done");
  endtask
  task automatic t_err;
    wr(CA, 8'h10);
    i_far.send_char(8'h6C, 1'b1, 1'b0);
    #1 chk(rx_holding_reg, 8'h6C);
    st(8'h90);
    i_far.send_char(8'h11, 1'b0, 1'b1);
    st(8'h90);
    wr(SA, 8'h00);
    i_far.send_char(8'h22, 1'b0, 1'b1);
    st(8'h88);
    $display("error test done");
  endtask
  task automatic t_tx;
    wr(SA, 8'h00);
    wr(CA, 8'h20);
    dma_tx_data <= 8'hC3;
    pulse(3);
    chk(tx_holding_reg, 8'hC3);
    st(8'h00);
    chk({7'h00, tx_go_reg}, 8'h01);
    pulse(2);
    st(8'h80);
    pulse(1);
    pulse(3);
    wr(CA, 8'h00);
    st(8'h80);
    $display("transmit test done");
  endtask
  task automatic t_clk;
    logic [7:0] m [5] = '{8'h00, 8'h01, 8'h80, 8'h03, 8'h82};
    logic [7:0] oe [5] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h01};
    logic [7:0] nt [5] = '{8'h04, 8'h04, 8'h04, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      wr(CA, m[i]);
      repeat (14) @(posedge mclk);
      chk({7'h00, sclk_oe_n}, oe[i]);
      chk({7'h00, use_ext_clk_reg}, {7'h00, m[i][1]});
      #1 n_int = 0;
      repeat (16) @(posedge mclk);
      #1 chk(8'(n_int), nt[i]);
    end
    n_edge = 0;
    i_far.send_clocks(5);
    repeat (6) @(posedge mclk);
    chk(8'(n_edge), 8'h05);
    wr(CA, 8'h03);
    n_tick = 0;
    i_far.send_clocks(32);
    repeat (6) @(posedge mclk);
    chk(8'(n_tick), 8'h02);
    $display("clock test done");
  endtask
  task automatic t_standby;
    logic [7:0] d;
    wr(CA, 8'h10);
    i_far.send_char(8'hC2, 1'b0, 1'b0);
    rd(SA, d);
    chk(d, 8'hC6);
    standby <= 1'b1;
    @(posedge mclk);
    st(8'h80);
    standby <= 1'b0;
    st(8'h80);
    $display("standby test done");
  endtask
  // ===========================================================
  // run control
  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    n_tick += int'(ext_bit_tick_reg);
    n_edge += int'(ext_sync_edge_reg);
    n_int += int'(int_bit_tick);
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end
  initial begin
    {arst_n, standby, reg_wr, reg_rd} = 4'h0;
    {dma_tx_write, tx_shift_load, tx_last_bit_done, dma_rx_read} = 4'h0;
    {reg_addr, reg_wdata, dma_tx_data} = 20'h00000;
    {n_mismatch, tests_run, n_tick, n_edge, cyc, n_int} = '0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset;
    t_rx;
    t_err;
    t_tx;
    t_clk;
    t_standby;
    complete_run;
  end
endmodule

// ==== verilog/bit_clock_gen.sv ====
// bit-rate square wave generator for the serial clock pin
`timescale 1ns/1ps
module bit_clock_gen #(
  parameter logic [7:0] HALF = serial_pkg::BIT_HALF_CYCLES
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic enable,
  output logic      clk_out_reg,
  output logic      bit_tick_reg
);
  logic [7:0] cnt_reg;
  logic       wrap;

  assign wrap = (cnt_reg == HALF - 8'h01);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg      <= 8'h00;
      clk_out_reg  <= 1'b1;
      bit_tick_reg <= 1'b0;
    end else if (!enable) begin
      cnt_reg      <= 8'h00;
      clk_out_reg  <= 1'b1;
      bit_tick_reg <= 1'b0;
    end else begin
      cnt_reg      <= wrap ? 8'h00 : cnt_reg + 8'h01;
      clk_out_reg  <= wrap ? ~clk_out_reg : clk_out_reg;
      bit_tick_reg <= wrap & ~clk_out_reg;
    end
  end
endmodule

// ==== verilog/pin_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ==== verilog/serial_status_clk_sel.sv ====
// serial status register and serial clock source selection
//
// Overview of operation
// R1: async, internal clock, no clock out: clock pin ignored, not driven.
// R2: sync mode, internal clock: drive the serial clock out on the pin.
// R3: async, internal clock, clock out enabled: bit-rate clock on the pin.
// R4: async, external clock: pin is input at sixteen times the bit rate.
// R5: sync mode, external clock: pin takes the synchronous serial clock.
// R6: status is eight bits laid out as the field constants show.
// R7: power-on reset or standby loads status with 84 hex.
// R8: writing 1 to a flag does nothing; 0 clears only after reading 1.
// R9: tx_complete and mp_bit_received ignore software writes.
// R10: tx_buffer_empty clears on armed write 0 or a DMA data write.
// R11: tx_buffer_empty sets on reset, standby, tx_on low, or shift load.
// R12: rx_buffer_full sets when a clean character reaches the holding reg.
// R13: rx_buffer_full clears on reset, standby, armed write 0, DMA read.
// R14: receive errors still load holding data but leave the full flag; rx_on low leaves both.
// R15: character ending while full sets overrun and drops the new one.
// R16: overrun halts reception; in sync mode transmission stops too.
// R17: overrun clears only on reset, standby or armed write 0.
// R18: clock out enable counts only in async mode with internal clock.
// R19: while tx_on is low the transmitter idles and tx empty stays 1.
// R20: a read that returns 1 arms the flag; the next write consumes it.
// R21: a hardware set beats a software clear in the same cycle.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module serial_status_clk_sel #(
  parameter logic [7:0] BIT_HALF = serial_pkg::BIT_HALF_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       standby,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       dma_tx_write,
  input  wire logic [7:0] dma_tx_data,
  input  wire logic       dma_rx_read,
  output logic      [7:0] rx_holding_reg,
  output logic      [7:0] tx_holding_reg,
  input  wire logic       tx_shift_load,
  input  wire logic       tx_last_bit_done,
  output logic            tx_go_reg,
  output logic            mp_send_reg,
  input  wire logic       rx_char_done,
  input  wire logic [7:0] rx_char_data,
  input  wire logic       rx_char_frame_err,
  input  wire logic       rx_char_parity_err,
  input  wire logic       rx_char_mp_bit,
  output logic            rx_go_reg,
  input  wire logic       sclk_in,
  output logic            sclk_out,
  output logic            sclk_oe_n,
  output logic            use_ext_clk_reg,
  output logic            ext_bit_tick_reg,
  output logic            ext_sync_edge_reg,
  output logic            int_bit_tick
);
  // ===========================================================
  // registers
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:3] armed_reg;
  logic [7:3] armed_next;
  logic [7:0] control_reg;
  logic [7:0] rdata_next;
  logic [7:0] rx_holding_next;
  logic [7:0] tx_holding_next;
  logic       sclk_sync;
  logic       sclk_prev_reg;
  logic [4:0] ext_cnt_reg;
  logic [4:0] ext_cnt_next;
  logic       gen_clk;
  logic       gen_tick;
  logic       sclk_out_next;
  logic       sclk_oe_n_next;

  // ===========================================================
  // address decode
  logic st_wr;
  logic st_rd;
  logic ctl_wr;
  logic txd_wr;
  assign st_wr  = reg_wr && (reg_addr == serial_pkg::STATUS_ADDR);
  assign st_rd  = reg_rd && (reg_addr == serial_pkg::STATUS_ADDR);
  assign ctl_wr = reg_wr && (reg_addr == serial_pkg::CONTROL_ADDR);
  assign txd_wr = reg_wr && (reg_addr == serial_pkg::TX_DATA_ADDR);

  assign rdata_next =
    (reg_addr == serial_pkg::STATUS_ADDR)  ? status_reg :
    (reg_addr == serial_pkg::CONTROL_ADDR) ? control_reg :
    (reg_addr == serial_pkg::TX_DATA_ADDR) ? tx_holding_reg :
    (reg_addr == serial_pkg::RX_DATA_ADDR) ? rx_holding_reg :
    8'h00;

  // ===========================================================
  // control fields
  logic tx_on;
  logic rx_on;
  logic sync_mode;
  logic ext_clk;
  logic clk_out_en;
  assign tx_on      = control_reg[serial_pkg::TX_ON_BIT];
  assign rx_on      = control_reg[serial_pkg::RX_ON_BIT];
  assign sync_mode  = control_reg[serial_pkg::SYNC_MODE_BIT];
  assign ext_clk    = control_reg[serial_pkg::CLK_SRC_BIT];
  assign clk_out_en = control_reg[serial_pkg::CLK_OUT_EN_BIT];

  // ===========================================================
  // flag clears by software
  logic [7:3] sw_clr;
  assign sw_clr = {5{st_wr}} & armed_reg & ~reg_wdata[7:3]; // R8 R20

  // ===========================================================
  // receive side
  logic rx_halt;
  logic rx_accept;
  logic rx_store;
  logic rx_err;
  logic rx_buffer_full_set;
  logic overrun_flag_set;
  logic fer_set;
  logic per_set;
  logic rx_buffer_full_clr;
  assign rx_halt   = status_reg[serial_pkg::OVERRUN_BIT]
                   | status_reg[serial_pkg::FRAMING_BIT]
                   | status_reg[serial_pkg::PARITY_BIT];
  assign rx_accept = rx_char_done & rx_on & ~rx_halt; // R16
  assign rx_err    = rx_char_frame_err | rx_char_parity_err;
  assign rx_store  = rx_accept
                   & ~status_reg[serial_pkg::RX_FULL_BIT]; // R15
  assign rx_buffer_full_set  = rx_store & ~rx_err; // R12 R14
  assign overrun_flag_set  = rx_accept
                   & status_reg[serial_pkg::RX_FULL_BIT]; // R15
  assign fer_set   = rx_store & rx_char_frame_err;
  assign per_set   = rx_store & rx_char_parity_err;
  assign rx_buffer_full_clr  = sw_clr[serial_pkg::RX_FULL_BIT]
                   | dma_rx_read; // R13

  assign rx_holding_next = rx_store ? rx_char_data : rx_holding_reg;

  // ===========================================================
  // transmit side
  logic tx_buffer_empty_set;
  logic tx_buffer_empty_clr;
  logic tx_complete_set;
  assign tx_buffer_empty_set = ~tx_on | tx_shift_load; // R11 R19
  assign tx_buffer_empty_clr = sw_clr[serial_pkg::TX_EMPTY_BIT]
                  | dma_tx_write; // R10
  assign tx_complete_set = ~tx_on
                  | (tx_last_bit_done
                     & status_reg[serial_pkg::TX_EMPTY_BIT]);

  assign tx_holding_next = dma_tx_write ? dma_tx_data :
                           txd_wr       ? reg_wdata   :
                           tx_holding_reg;

  // ===========================================================
  // status next value
  always_comb begin
    status_next = status_reg;
    // set wins over clear for every flag
    status_next[serial_pkg::TX_EMPTY_BIT] = tx_buffer_empty_set // R21
      | (status_reg[serial_pkg::TX_EMPTY_BIT] & ~tx_buffer_empty_clr);
    status_next[serial_pkg::RX_FULL_BIT] = rx_buffer_full_set // R21
      | (status_reg[serial_pkg::RX_FULL_BIT] & ~rx_buffer_full_clr);
    status_next[serial_pkg::OVERRUN_BIT] = overrun_flag_set // R17
      | (status_reg[serial_pkg::OVERRUN_BIT]
         & ~sw_clr[serial_pkg::OVERRUN_BIT]);
    status_next[serial_pkg::FRAMING_BIT] = fer_set
      | (status_reg[serial_pkg::FRAMING_BIT]
         & ~sw_clr[serial_pkg::FRAMING_BIT]);
    status_next[serial_pkg::PARITY_BIT] = per_set
      | (status_reg[serial_pkg::PARITY_BIT]
         & ~sw_clr[serial_pkg::PARITY_BIT]);
    // read-only bits follow hardware only
    status_next[serial_pkg::TX_DONE_BIT] = tx_complete_set // R9
      | (status_reg[serial_pkg::TX_DONE_BIT] & ~tx_buffer_empty_clr);
    if (rx_store) begin
      status_next[serial_pkg::MP_RX_BIT] = rx_char_mp_bit; // R9
    end
    if (st_wr) begin
      status_next[serial_pkg::MP_TX_BIT] =
        reg_wdata[serial_pkg::MP_TX_BIT];
    end
    if (standby) begin
      status_next = serial_pkg::STATUS_RESET; // R7
    end
  end

  // arm on a read of 1, consume on any status write, drop once clear
  assign armed_next = standby ? 5'h00 : // R20
    ((st_wr ? 5'h00 : armed_reg)
     | (st_rd ? status_reg[7:3] : 5'h00)) & status_next[7:3];

  // ===========================================================
  // serial clock pin selection
  logic drive_clk;
  logic ext_rise;
  logic ext_wrap;
  // clock out enable only matters in async mode, internal clock
  assign drive_clk = ~ext_clk & (sync_mode | clk_out_en); // R1 R2 R3 R18
  assign sclk_out_next  = drive_clk ? gen_clk : 1'b1;
  assign sclk_oe_n_next = ~drive_clk; // R1
  assign ext_rise  = ext_clk & sclk_sync & ~sclk_prev_reg; // R4 R5
  assign ext_wrap  = (ext_cnt_reg == serial_pkg::EXT_OVERSAMPLE - 5'h01);
  assign ext_cnt_next = (~ext_clk | sync_mode) ? 5'h00 :
                        ~ext_rise ? ext_cnt_reg :
                        ext_wrap  ? 5'h00 : ext_cnt_reg + 5'h01;

  pin_sync #(
    .W (1)
  ) u_sclk_sync (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .async_in (sclk_in),
    .sync_out (sclk_sync)
  );

  bit_clock_gen #(
    .HALF (BIT_HALF)
  ) u_bit_clk (
    .mclk         (mclk),
    .arst_n       (arst_n),
    .enable       (~ext_clk),
    .clk_out_reg  (gen_clk),
    .bit_tick_reg (gen_tick)
  );

  assign int_bit_tick = gen_tick;

  // ===========================================================
  // status, arming and data registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg     <= serial_pkg::STATUS_RESET; // R7
      armed_reg      <= 5'h00;
      rx_holding_reg <= 8'h00;
      tx_holding_reg <= 8'h00;
    end else begin
      status_reg     <= status_next; // R6
      armed_reg      <= armed_next;
      rx_holding_reg <= rx_holding_next; // R14
      tx_holding_reg <= tx_holding_next;
    end
  end

  // ===========================================================
  // control register and read data
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      control_reg <= serial_pkg::CONTROL_RESET;
      reg_rdata   <= 8'h00;
    end else begin
      if (ctl_wr) begin
        control_reg <= reg_wdata & serial_pkg::CONTROL_MASK;
      end
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end

  // ===========================================================
  // engine handshakes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_go_reg   <= 1'b0;
      rx_go_reg   <= 1'b0;
      mp_send_reg <= 1'b0;
    end else begin
      tx_go_reg   <= tx_on // R19
        & ~status_next[serial_pkg::TX_EMPTY_BIT]
        & ~(sync_mode & (|status_next[5:3])); // R16
      rx_go_reg   <= rx_on & ~(|status_next[5:3]); // R16
      mp_send_reg <= status_next[serial_pkg::MP_TX_BIT];
    end
  end

  // ===========================================================
  // clock pin outputs and external clock ticks
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_out          <= 1'b1;
      sclk_oe_n         <= 1'b1;
      sclk_prev_reg     <= 1'b0;
      ext_cnt_reg       <= 5'h00;
      use_ext_clk_reg   <= 1'b0;
      ext_bit_tick_reg  <= 1'b0;
      ext_sync_edge_reg <= 1'b0;
    end else begin
      sclk_out          <= sclk_out_next; // R2 R3
      sclk_oe_n         <= sclk_oe_n_next;
      sclk_prev_reg     <= sclk_sync;
      ext_cnt_reg       <= ext_cnt_next;
      use_ext_clk_reg   <= ext_clk;
      ext_bit_tick_reg  <= ext_rise & ~sync_mode & ext_wrap; // R4
      ext_sync_edge_reg <= ext_rise & sync_mode; // R5
    end
  end
endmodule
